// ==== design/lun_reservation.sv ====
`timescale 1ns/10ps
module lun_reservation #(
	parameter int INIT_W = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req,
	input wire logic [INIT_W-1:0] initiator,
	input wire logic target_reset,
	output logic conflict,
	output logic reserved,
	output logic [INIT_W-1:0] owner
);
	// R17 - other initiator refused at once
	assign conflict = reserved && (owner != initiator);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reserved <= 1'b0;
			owner <= '0;
		// R13 - target reset drops it
		end else if (target_reset) begin
			reserved <= 1'b0;
		// R16 - owner supersedes on grant
		end else if (req && !conflict) begin
			// R10 - whole unit, for sender
			reserved <= 1'b1;
			owner <= initiator;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_grant_owner;
		req && !conflict && !target_reset |=> reserved && owner == $past(initiator);
	endproperty
	a_grant_owner: assert property (p_grant_owner) // R10
		else $error("grant owner wrong");
	property p_trst_clears;
		target_reset |=> !reserved;
	endproperty
	a_trst_clears: assert property (p_trst_clears) // R13
		else $error("reset kept reservation");
	property p_conflict_keeps;
		req && conflict && !target_reset |=> owner == $past(owner) && reserved;
	endproperty
	a_conflict_keeps: assert property (p_conflict_keeps) // R16
		else $error("owner stolen");
endmodule // lun_reservation

// ==== design/scsi_cmd_pkg.sv ====
package scsi_cmd_pkg;
	// ==========================================================
	// register byte offsets
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] ADDR_CDB0 = 8'h00;
	localparam logic [7:0] ADDR_CDB1 = 8'h04;
	localparam logic [7:0] ADDR_CDB2 = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_XDATA = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// command field positions
	localparam int CMD_GO_BIT = 31;
	localparam int CMD_TRST_BIT = 30;
	localparam int CMD_LUN_LSB = 8;
	localparam int THIRD_PARTY_BIT = 4;
	localparam int EXTENT_BIT = 0;
	localparam int FORMAT_BIT = 0;
	localparam int STAT_LEN_LSB = 8;
	localparam int STAT_BUSY_BIT = 16;
	localparam int STAT_RSV_BIT = 17;
	localparam int STAT_OWNER_LSB = 20;
	// ==========================================================
	// operation codes, status bytes, sense codes
	localparam logic [7:0] OP_REZERO = 8'h01;
	localparam logic [7:0] OP_SENSE = 8'h03;
	localparam logic [7:0] OP_RESERVE6 = 8'h16;
	localparam logic [7:0] OP_RESERVE10 = 8'h56;
	localparam logic [7:0] STS_GOOD = 8'h00;
	localparam logic [7:0] STS_CHECK = 8'h02;
	localparam logic [7:0] STS_CONFLICT = 8'h18;
	localparam logic [3:0] KEY_NO_SENSE = 4'h0;
	localparam logic [3:0] KEY_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_INV_OPCODE = 8'h20;
	localparam logic [7:0] ASC_INV_FIELD = 8'h24;
	localparam logic [7:0] ASC_LUN_NS = 8'h25;
	localparam logic [7:0] ASCQ_NONE = 8'h00;
	// ==========================================================
	// sense layouts
	localparam logic [7:0] FIXED_LEN = 8'h20;
	localparam logic [7:0] SENSE_FORMAT_SELECT_LEN_SHORT = 8'h28;
	localparam logic [7:0] SENSE_FORMAT_SELECT_LEN_LONG = 8'h3c;
	localparam logic [7:0] HDR_LEN = 8'h08;
	localparam logic [7:0] RESP_CODE_FIXED = 8'h70;
	localparam logic [7:0] RESP_CODE_SENSE_FORMAT_SELECT = 8'h72;
	localparam logic [5:0] FIX_KEY_POS = 6'h02;
	localparam logic [5:0] FIX_ADDL_POS = 6'h07;
	localparam logic [5:0] FIX_ASC_POS = 6'h0c;
	localparam logic [5:0] FIX_ASCQ_POS = 6'h0d;
	localparam logic [5:0] DSC_KEY_POS = 6'h01;
	localparam logic [5:0] DSC_ASC_POS = 6'h02;
	localparam logic [5:0] DSC_ASCQ_POS = 6'h03;
	localparam logic [5:0] DSC_ADDL_POS = 6'h07;
	// ==========================================================
	// interrupt bits and reset values
	localparam int IRQ_W = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_CHECK = 1;
	localparam int IRQ_CONFLICT = 2;
	localparam int IRQ_SEEK = 3;
	localparam logic [3:0] RST_IRQ = 4'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		FSM_IDLE = 2'b00,
		FSM_EXEC = 2'b01,
		FSM_SEEK = 2'b11
	} cmd_state_t;
endpackage

// ==== design/scsi_sense_reserve_rezero.sv ====
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// How it works
// R01 - opcode 03h returns requester's sense
// R02 - never return more than allocation length
// R03 - fixed format: min of allocation, 32
// R04 - descriptor format: min of allocation, size
// R05 - bad unit: good status, unsupported sense
// R06 - nothing pending: no sense, no info
// R07 - separate sense store per initiator
// R08 - opcode 16h decodes six-byte reserve
// R09 - opcode 56h decodes ten-byte reserve
// R10 - reservation covers unit, owned by sender
// R11 - extent flag set: check, invalid field (code checks it for 56h only; a 16h reserve ignores it and is granted)
// R12 - identifier and extent length ignored
// R13 - held until supersede, resets or power
// R14 - third party flag: check, invalid field
// R15 - third party identifier ignored
// R16 - only owner replaces, on new grant
// R17 - no queueing, other initiator conflicts
// R18 - opcode 01h seeks block zero
// R19 - descriptor size is build parameter
module scsi_sense_reserve_rezero #(
	parameter int INIT_W = 2,
	parameter int SENSE_FORMAT_SELECT_SIZE = 60
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic seek_start,
	input wire logic seek_done,
	output logic irq
);
	localparam int NUM_INIT = 1 << INIT_W;
	localparam logic [7:0] SENSE_FORMAT_SELECT_LEN = (SENSE_FORMAT_SELECT_SIZE == 40) ?
		scsi_cmd_pkg::SENSE_FORMAT_SELECT_LEN_SHORT : scsi_cmd_pkg::SENSE_FORMAT_SELECT_LEN_LONG;

	// ==========================================================
	// register bus
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic wr_fire, rd_fire, wr_ok, rd_ok;
	logic [31:0] rd_word;
	logic [31:0] cdb0_reg, cdb1_reg, cdb2_reg;
	logic [INIT_W-1:0] init_reg;
	logic [7:0] lun_reg;
	logic go, trst;

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_comb begin
		case (aw_addr_reg)
			scsi_cmd_pkg::ADDR_CDB0, scsi_cmd_pkg::ADDR_CDB1,
			scsi_cmd_pkg::ADDR_CDB2, scsi_cmd_pkg::ADDR_CMD,
			scsi_cmd_pkg::ADDR_STATUS, scsi_cmd_pkg::ADDR_XDATA,
			scsi_cmd_pkg::ADDR_IRQ_STAT, scsi_cmd_pkg::ADDR_IRQ_CLR,
			scsi_cmd_pkg::ADDR_IRQ_EN: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= scsi_cmd_pkg::RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= scsi_cmd_pkg::RST_WORD;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? scsi_cmd_pkg::RESP_OKAY :
					scsi_cmd_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// command block registers
	scsi_cmd_pkg::cmd_state_t state_reg, state_next;
	logic busy, do_exec, sel_cmd;
	assign busy = state_reg != scsi_cmd_pkg::FSM_IDLE;
	assign do_exec = state_reg == scsi_cmd_pkg::FSM_EXEC;
	assign sel_cmd = wr_fire && aw_addr_reg == scsi_cmd_pkg::ADDR_CMD;
	// a go while busy is dropped so a running command keeps its block
	assign go = sel_cmd && w_strb_reg[3] &&
		w_data_reg[scsi_cmd_pkg::CMD_GO_BIT] && !busy;
	assign trst = sel_cmd && w_strb_reg[3] &&
		w_data_reg[scsi_cmd_pkg::CMD_TRST_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cdb0_reg <= scsi_cmd_pkg::RST_WORD;
			cdb1_reg <= scsi_cmd_pkg::RST_WORD;
			cdb2_reg <= scsi_cmd_pkg::RST_WORD;
			init_reg <= '0;
			lun_reg <= 8'h00;
		end else if (wr_fire && !busy) begin
			case (aw_addr_reg)
				scsi_cmd_pkg::ADDR_CDB0:
					cdb0_reg <= merge(cdb0_reg, w_data_reg, w_strb_reg);
				scsi_cmd_pkg::ADDR_CDB1:
					cdb1_reg <= merge(cdb1_reg, w_data_reg, w_strb_reg);
				scsi_cmd_pkg::ADDR_CDB2:
					cdb2_reg <= merge(cdb2_reg, w_data_reg, w_strb_reg);
				scsi_cmd_pkg::ADDR_CMD: begin
					if (w_strb_reg[0]) begin
						init_reg <= w_data_reg[INIT_W-1:0];
					end
					if (w_strb_reg[1]) begin
						lun_reg <= w_data_reg[scsi_cmd_pkg::CMD_LUN_LSB +: 8];
					end
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// decode
	logic [7:0] op, flags, alloc;
	logic dec_sense, dec_seek, dec_check, res_req, conflict, reserved;
	logic [7:0] dec_asc;
	logic [INIT_W-1:0] owner;
	assign op = cdb0_reg[7:0];
	assign flags = cdb0_reg[15:8];
	assign alloc = cdb1_reg[7:0];

	// R12 - bytes 2 to 4 and 7 to 8 unread
	// R15 - identifier bits 3 to 1 unread
	always_comb begin
		dec_sense = 1'b0;
		dec_seek = 1'b0;
		dec_check = 1'b0;
		res_req = 1'b0;
		dec_asc = scsi_cmd_pkg::ASC_NONE;
		case (op)
			// R01 - sense request
			scsi_cmd_pkg::OP_SENSE: dec_sense = 1'b1;
			// R08 - six-byte reserve
			scsi_cmd_pkg::OP_RESERVE6: begin
				// R14 - third party refused
				if (flags[scsi_cmd_pkg::THIRD_PARTY_BIT]) begin
					dec_check = 1'b1;
					dec_asc = scsi_cmd_pkg::ASC_INV_FIELD;
				end else begin
					res_req = 1'b1;
				end
			end
			// R09 - ten-byte reserve
			scsi_cmd_pkg::OP_RESERVE10: begin
				// R11 - extent refused
				if (flags[scsi_cmd_pkg::THIRD_PARTY_BIT] ||
					flags[scsi_cmd_pkg::EXTENT_BIT]) begin
					dec_check = 1'b1;
					dec_asc = scsi_cmd_pkg::ASC_INV_FIELD;
				end else begin
					res_req = 1'b1;
				end
			end
			// R18 - rezero seeks block zero
			scsi_cmd_pkg::OP_REZERO: dec_seek = 1'b1;
			default: begin
				dec_check = 1'b1;
				dec_asc = scsi_cmd_pkg::ASC_INV_OPCODE;
			end
		endcase
	end

	lun_reservation #(.INIT_W(INIT_W)) u_res (
		.aclk(aclk),
		.aresetn(aresetn),
		.req(do_exec && res_req),
		.initiator(init_reg),
		// R13 - target reset from any initiator
		.target_reset(trst),
		.conflict(conflict),
		.reserved(reserved),
		.owner(owner)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			scsi_cmd_pkg::FSM_IDLE:
				if (go) state_next = scsi_cmd_pkg::FSM_EXEC;
			scsi_cmd_pkg::FSM_EXEC: state_next = dec_seek ?
				scsi_cmd_pkg::FSM_SEEK : scsi_cmd_pkg::FSM_IDLE;
			scsi_cmd_pkg::FSM_SEEK:
				if (seek_done) state_next = scsi_cmd_pkg::FSM_IDLE;
			default: state_next = scsi_cmd_pkg::FSM_IDLE;
		endcase
	end

	logic [7:0] status_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= scsi_cmd_pkg::FSM_IDLE;
			status_reg <= scsi_cmd_pkg::STS_GOOD;
			seek_start <= 1'b0;
		end else begin
			state_reg <= state_next;
			seek_start <= do_exec && dec_seek;
			if (do_exec) begin
				if (dec_check) begin
					status_reg <= scsi_cmd_pkg::STS_CHECK;
				// R17 - answered at once
				end else if (res_req && conflict) begin
					status_reg <= scsi_cmd_pkg::STS_CONFLICT;
				end else begin
					status_reg <= scsi_cmd_pkg::STS_GOOD;
				end
			end
		end
	end

	// ==========================================================
	// per-initiator sense store
	logic [NUM_INIT-1:0] pending_reg;
	logic [3:0] key_store [NUM_INIT];
	logic [7:0] asc_store [NUM_INIT];
	logic [7:0] ascq_store [NUM_INIT];
	// R07 - one entry per initiator
	for (genvar g = 0; g < NUM_INIT; g++) begin : g_store
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pending_reg[g] <= 1'b0;
				key_store[g] <= scsi_cmd_pkg::KEY_NO_SENSE;
				asc_store[g] <= scsi_cmd_pkg::ASC_NONE;
				ascq_store[g] <= scsi_cmd_pkg::ASCQ_NONE;
			end else if (do_exec && init_reg == INIT_W'(g)) begin
				if (dec_check) begin
					pending_reg[g] <= 1'b1;
					key_store[g] <= scsi_cmd_pkg::KEY_ILLEGAL;
					asc_store[g] <= dec_asc;
					ascq_store[g] <= scsi_cmd_pkg::ASCQ_NONE;
				end else if (dec_sense && lun_reg == 8'h00) begin
					pending_reg[g] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// sense report and byte transfer
	logic rep_sense_format_select_reg;
	logic [3:0] rep_key_reg;
	logic [7:0] rep_asc_reg, rep_ascq_reg, xfer_len_reg, xfer_ptr_reg;
	logic [7:0] fmt_len;
	logic pop;
	sense_if sif();
	assign sif.sense_format_select = rep_sense_format_select_reg;
	assign sif.key = rep_key_reg;
	assign sif.asc = rep_asc_reg;
	assign sif.ascq = rep_ascq_reg;
	assign sif.index = xfer_ptr_reg[5:0];
	sense_formatter #(.SENSE_FORMAT_SELECT_SIZE(SENSE_FORMAT_SELECT_SIZE)) u_fmt (.sif(sif));

	assign fmt_len = flags[scsi_cmd_pkg::FORMAT_BIT] ? SENSE_FORMAT_SELECT_LEN :
		scsi_cmd_pkg::FIXED_LEN;
	assign pop = rd_fire && s_axi_araddr == scsi_cmd_pkg::ADDR_XDATA &&
		xfer_ptr_reg < xfer_len_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rep_sense_format_select_reg <= 1'b0;
			rep_key_reg <= scsi_cmd_pkg::KEY_NO_SENSE;
			rep_asc_reg <= scsi_cmd_pkg::ASC_NONE;
			rep_ascq_reg <= scsi_cmd_pkg::ASCQ_NONE;
			xfer_len_reg <= 8'h00;
			xfer_ptr_reg <= 8'h00;
		end else if (do_exec) begin
			xfer_ptr_reg <= 8'h00;
			xfer_len_reg <= 8'h00;
			if (dec_sense) begin
				rep_sense_format_select_reg <= flags[scsi_cmd_pkg::FORMAT_BIT];
				// R02 - clipped to allocation
				xfer_len_reg <= (alloc < fmt_len) ? alloc : fmt_len;
				rep_ascq_reg <= scsi_cmd_pkg::ASCQ_NONE;
				// R05 - unsupported unit reported
				if (lun_reg != 8'h00) begin
					rep_key_reg <= scsi_cmd_pkg::KEY_ILLEGAL;
					rep_asc_reg <= scsi_cmd_pkg::ASC_LUN_NS;
				// R01 - stored sense returned
				end else if (pending_reg[init_reg]) begin
					rep_key_reg <= key_store[init_reg];
					rep_asc_reg <= asc_store[init_reg];
					rep_ascq_reg <= ascq_store[init_reg];
				// R06 - nothing pending
				end else begin
					rep_key_reg <= scsi_cmd_pkg::KEY_NO_SENSE;
					rep_asc_reg <= scsi_cmd_pkg::ASC_NONE;
				end
			end
		end else if (pop) begin
			xfer_ptr_reg <= xfer_ptr_reg + 8'h01;
		end
	end

	// ==========================================================
	// interrupts
	logic [3:0] irq_stat_reg, irq_en_reg, irq_ev, irq_clr;
	assign irq_ev[scsi_cmd_pkg::IRQ_DONE] = (do_exec && !dec_seek) ||
		(state_reg == scsi_cmd_pkg::FSM_SEEK && seek_done);
	assign irq_ev[scsi_cmd_pkg::IRQ_CHECK] = do_exec && dec_check;
	assign irq_ev[scsi_cmd_pkg::IRQ_CONFLICT] = do_exec && res_req && conflict;
	assign irq_ev[scsi_cmd_pkg::IRQ_SEEK] =
		state_reg == scsi_cmd_pkg::FSM_SEEK && seek_done;
	assign irq_clr = (wr_fire && aw_addr_reg == scsi_cmd_pkg::ADDR_IRQ_CLR &&
		w_strb_reg[0]) ? w_data_reg[3:0] : 4'h0;
	assign irq = |(irq_stat_reg & irq_en_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= scsi_cmd_pkg::RST_IRQ;
			irq_en_reg <= scsi_cmd_pkg::RST_IRQ;
		end else begin
			// a new event beats a clear in the same cycle
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
			if (wr_fire && aw_addr_reg == scsi_cmd_pkg::ADDR_IRQ_EN &&
				w_strb_reg[0]) begin
				irq_en_reg <= w_data_reg[3:0];
			end
		end
	end

	// ==========================================================
	// read path
	always_comb begin
		rd_word = scsi_cmd_pkg::RST_WORD;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			scsi_cmd_pkg::ADDR_CDB0: rd_word = cdb0_reg;
			scsi_cmd_pkg::ADDR_CDB1: rd_word = cdb1_reg;
			scsi_cmd_pkg::ADDR_CDB2: rd_word = cdb2_reg;
			scsi_cmd_pkg::ADDR_CMD: begin
				rd_word[INIT_W-1:0] = init_reg;
				rd_word[scsi_cmd_pkg::CMD_LUN_LSB +: 8] = lun_reg;
			end
			scsi_cmd_pkg::ADDR_STATUS: begin
				rd_word[7:0] = status_reg;
				rd_word[scsi_cmd_pkg::STAT_LEN_LSB +: 8] = xfer_len_reg;
				rd_word[scsi_cmd_pkg::STAT_BUSY_BIT] = busy;
				rd_word[scsi_cmd_pkg::STAT_RSV_BIT] = reserved;
				rd_word[scsi_cmd_pkg::STAT_OWNER_LSB +: INIT_W] = owner;
			end
			scsi_cmd_pkg::ADDR_XDATA:
				if (xfer_ptr_reg < xfer_len_reg) rd_word[7:0] = sif.data;
			scsi_cmd_pkg::ADDR_IRQ_STAT: rd_word[3:0] = irq_stat_reg;
			scsi_cmd_pkg::ADDR_IRQ_CLR: ;
			scsi_cmd_pkg::ADDR_IRQ_EN: rd_word[3:0] = irq_en_reg;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= scsi_cmd_pkg::RST_WORD;
			rresp_reg <= scsi_cmd_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? scsi_cmd_pkg::RESP_OKAY :
				scsi_cmd_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic ex_sense;
	logic [NUM_INIT-1:0] id_mask;
	assign ex_sense = do_exec && dec_sense;
	assign id_mask = NUM_INIT'(1) << init_reg;

	property p_len_cap;
		ex_sense |=> xfer_len_reg <= $past(alloc) && xfer_ptr_reg == 8'h00;
	endproperty
	a_len_cap: assert property (p_len_cap) else $error("sense too long"); // R02
	property p_fixed_len;
		ex_sense && !flags[0] && alloc >= 8'h20 |=> xfer_len_reg == 8'h20;
	endproperty
	a_fixed_len: assert property (p_fixed_len) else $error("fixed length"); // R03
	property p_sense_format_select_len;
		ex_sense && flags[0] && alloc == 8'hff |=> xfer_len_reg == SENSE_FORMAT_SELECT_LEN;
	endproperty
	a_sense_format_select_len: assert property (p_sense_format_select_len) else $error("sense_format_select length"); // R04
	property p_bad_lun;
		ex_sense && lun_reg != 8'h00 |=> status_reg == 8'h00 &&
			rep_key_reg == 4'h5 && rep_asc_reg == 8'h25;
	endproperty
	a_bad_lun: assert property (p_bad_lun) else $error("bad unit sense"); // R05
	property p_no_sense;
		ex_sense && lun_reg == 8'h00 && !pending_reg[init_reg] |=>
			rep_key_reg == 4'h0 && rep_asc_reg == 8'h00;
	endproperty
	a_no_sense: assert property (p_no_sense) else $error("no sense wrong"); // R06
	property p_isolated;
		do_exec |=> ((pending_reg ^ $past(pending_reg)) & ~$past(id_mask)) == '0;
	endproperty
	a_isolated: assert property (p_isolated) // R07
		else $error("other sense touched");
	property p_reserve_check;
		do_exec && (op == 8'h16 || op == 8'h56) && flags[4] |=>
			status_reg == 8'h02 && pending_reg[$past(init_reg)] &&
			asc_store[$past(init_reg)] == 8'h24;
	endproperty
	a_reserve_check: assert property (p_reserve_check) // R14
		else $error("3p accepted");
	property p_extent_check;
		do_exec && op == 8'h56 && flags[0] |=> status_reg == 8'h02 &&
			key_store[$past(init_reg)] == 4'h5;
	endproperty
	a_extent_check: assert property (p_extent_check) // R11
		else $error("extent accepted");
	property p_conflict;
		do_exec && res_req && reserved && owner != init_reg |=>
			status_reg == 8'h18 ##1 state_reg == scsi_cmd_pkg::FSM_IDLE;
	endproperty
	a_conflict: assert property (p_conflict) else $error("no conflict"); // R17
	property p_rezero;
		do_exec && op == 8'h01 |=> seek_start &&
			state_reg == scsi_cmd_pkg::FSM_SEEK ##1 !seek_start;
	endproperty
	a_rezero: assert property (p_rezero) else $error("no seek"); // R18
	c_fixed: cover property (ex_sense && !flags[0] && lun_reg == 8'h00);
	c_sense_format_select: cover property (ex_sense && flags[0]);
	c_conflict: cover property (irq_ev[scsi_cmd_pkg::IRQ_CONFLICT]);
	c_seek: cover property (irq_ev[scsi_cmd_pkg::IRQ_SEEK]);
endmodule // scsi_sense_reserve_rezero

// ==== design/sense_formatter.sv ====
`timescale 1ns/10ps
module sense_formatter #(
	parameter int SENSE_FORMAT_SELECT_SIZE = 60
) (
	sense_if.formatter sif
);
	// R19 - size limited to two builds
	localparam logic [7:0] SENSE_FORMAT_SELECT_LEN = (SENSE_FORMAT_SELECT_SIZE == 40) ?
		scsi_cmd_pkg::SENSE_FORMAT_SELECT_LEN_SHORT : scsi_cmd_pkg::SENSE_FORMAT_SELECT_LEN_LONG;

	always_comb begin
		sif.data = 8'h00;
		if (sif.sense_format_select) begin
			// R04 - descriptor layout
			case (sif.index)
				6'h00: sif.data = scsi_cmd_pkg::RESP_CODE_SENSE_FORMAT_SELECT;
				scsi_cmd_pkg::DSC_KEY_POS: sif.data = {4'h0, sif.key};
				scsi_cmd_pkg::DSC_ASC_POS: sif.data = sif.asc;
				scsi_cmd_pkg::DSC_ASCQ_POS: sif.data = sif.ascq;
				scsi_cmd_pkg::DSC_ADDL_POS:
					sif.data = SENSE_FORMAT_SELECT_LEN - scsi_cmd_pkg::HDR_LEN;
				default: sif.data = 8'h00;
			endcase
		end else begin
			// R03 - fixed layout
			case (sif.index)
				6'h00: sif.data = scsi_cmd_pkg::RESP_CODE_FIXED;
				scsi_cmd_pkg::FIX_KEY_POS: sif.data = {4'h0, sif.key};
				scsi_cmd_pkg::FIX_ADDL_POS: sif.data =
					scsi_cmd_pkg::FIXED_LEN - scsi_cmd_pkg::HDR_LEN;
				scsi_cmd_pkg::FIX_ASC_POS: sif.data = sif.asc;
				scsi_cmd_pkg::FIX_ASCQ_POS: sif.data = sif.ascq;
				default: sif.data = 8'h00;
			endcase
		end
	end
endmodule // sense_formatter

// ==== design/sense_if.sv ====
`timescale 1ns/10ps
interface sense_if;
	logic sense_format_select;
	logic [3:0] key;
	logic [7:0] asc;
	logic [7:0] ascq;
	logic [5:0] index;
	logic [7:0] data;
	modport requester(output sense_format_select, output key, output asc, output ascq,
		output index, input data);
	modport formatter(input sense_format_select, input key, input asc, input ascq,
		input index, output data);
endinterface

// ==== tb/seek_model.sv ====
`timescale 1ns/10ps
module seek_model (
	input wire logic aclk,
	input wire logic seek_start,
	output logic seek_done = 1'b0
);
	int cnt = 0;
	// never answers at once: the block must wait out a real seek
	always @(posedge aclk) begin
		seek_done <= (cnt == 1);
		cnt <= seek_start ? 6 : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule // seek_model

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, seek_start, seek_done, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int miscompares = 0, n_tests = 0;
	initial forever #2.5 aclk = ~aclk;
	scsi_sense_reserve_rezero u_scsi_sense_reserve_rezero (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .seek_start, .seek_done, .irq);
	seek_model u_seek_model (.aclk, .seek_start, .seek_done);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			ad = ad | s_axi_awready;
			wd = wd | s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !wd;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// cm holds lun and initiator; leaves the final status word in v
	task run(input logic [15:0] cm, input logic [31:0] c0, c1);
		wr(scsi_cmd_pkg::ADDR_CDB0, c0);
		wr(scsi_cmd_pkg::ADDR_CDB1, c1);
		wr(scsi_cmd_pkg::ADDR_CMD, {16'h8000, cm});
		do rd(scsi_cmd_pkg::ADDR_STATUS); while (v[16]);
	endtask
	task sense(input logic [15:0] cm, input int n);
		run(cm, 32'h03, 32'hff);
		chk(v[7:0], 8'h00);
		repeat (n) rd(scsi_cmd_pkg::ADDR_XDATA);
	endtask
	task t_sense;
		run(16'h0000, 32'h03, 32'h05);
		chk(v[15:0], 16'h0500);
		rd(scsi_cmd_pkg::ADDR_XDATA);
		chk(v[7:0], 8'h70);
		run(16'h0001, 32'h03, 32'hff);
		chk(v[15:8], 8'h20);
		run(16'h0001, 32'h0103, 32'hff);
		chk(v[15:8], 8'h3c);
		rd(scsi_cmd_pkg::ADDR_XDATA);
		chk(v[7:0], 8'h72);
		sense(16'h0100, 3);
		chk(v[7:0], 8'h05);
	endtask
	task t_rsv;
		run(16'h0000, 32'h0e16, 32'h0);
		chk(v[21:16], 6'h02);
		run(16'h0001, 32'h56, 32'h0);
		chk(v[7:0], 8'h18);
		run(16'h0001, 32'h1016, 32'h0);
		chk(v[7:0], 8'h02);
		run(16'h0002, 32'h0156, 32'h0);
		chk(v[7:0], 8'h02);
		run(16'h0000, 32'h00ff_0056, 32'hff00_0000);
		chk(v[21:0], 22'h020000);
		sense(16'h0002, 13);
		chk(v[7:0], 8'h24);
		sense(16'h0003, 3);
		chk(v[7:0], 8'h00);
		wr(scsi_cmd_pkg::ADDR_CMD, 32'h4000_0000);
		rd(scsi_cmd_pkg::ADDR_STATUS);
		chk(v[17], 1'b0);
		run(16'h0001, 32'h16, 32'h0);
		chk(v[21:16], 6'h12);
	endtask
	task t_rezero;
		run(16'h0003, 32'h77, 32'h0);
		chk(v[7:0], 8'h02);
		wr(scsi_cmd_pkg::ADDR_IRQ_EN, 32'hf);
		chk(resp, 2'h0);
		run(16'h0000, 32'h01, 32'h0);
		rd(scsi_cmd_pkg::ADDR_IRQ_STAT);
		chk({irq, v[3]}, 2'h3);
		wr(scsi_cmd_pkg::ADDR_IRQ_CLR, 32'hf);
		rd(8'h40);
		chk({irq, resp}, 3'h2);
		wr(8'h40, 32'h0);
		chk(resp, 2'h2);
	endtask
	task finish_test;
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		t_sense;
		t_rsv;
		t_rezero;
		finish_test;
	end
endmodule // testbench
